// ---- core/pirq_bank.sv ----
`timescale 1ns/100ps
// Overview of operation
// R1: enable bank 2 bit 7 gates capture/compare unit b request
// R2: enable bank 2 bit 6 gates nonvolatile completion request
// R3: enable bank 2 bit 5 gates timer b gate; other bits zero; reset 0
// R4: bank 1 and 2 sources need the peripheral gate as well
// R5: request bank 0 bit 5 sets on timer a overflow, sticky
// R6: request bank 0 bit 4 is live OR of per-pin change flags
// R7: request bank 0 bit 0 sets on edge of selected external pin
// R8: flags set regardless of their enables or the global gate
// R9: software should clear flags before setting their enables
// R10: request bank 1 bit 7 sets on capture/compare unit a event
// R11: bank 1 bits 6,5,1,0 set on timer c, b, sync serial, adc
// R12: bank 1 bit 4 read-only, high while rx buffer holds a byte
// R13: bank 1 bit 3 read-only, high while tx buffer is empty
// R14: bank 1 bit 2 sets on bus collision; cleared only by write
// R15: request bank 2 bit 7 sets on capture/compare unit b event
// R16: request bank 2 bit 6 sets on nonvolatile operation done
// R17: request bank 2 bit 5 sets when timer b gate goes inactive
// R18: bank 0 sources vector with global gate, no peripheral gate
// R19: external flag with its enable and global gate redirects cpu
// R20: cpu request is global gate and enabled flags, banks 1-2 gated
module pirq_bank #(
	parameter int unsigned EXT_PINS = 4,
	parameter int unsigned CHG_PINS = 12
) (
	// clock and reset
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	// axi4-lite write address
	input  wire logic [pirq_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                        s_axi_bresp,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	// axi4-lite read address
	input  wire logic [pirq_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	// axi4-lite read data
	output logic [31:0]                       s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	// peripheral event pulses, same clock
	input  wire logic                         timer_a_overflow,
	input  wire logic                         capcmp_a_event,
	input  wire logic                         timer_c_event,
	input  wire logic                         timer_b_event,
	input  wire logic                         sync_serial_event,
	input  wire logic                         sync_serial_collision,
	input  wire logic                         adc_done_event,
	input  wire logic                         capcmp_b_event,
	input  wire logic                         nonvol_done_event,
	input  wire logic                         timer_b_gate_inactive,
	// peripheral status levels, same clock
	input  wire logic [CHG_PINS-1:0]          per_pin_change_flags,
	input  wire logic                         async_rx_pending,
	input  wire logic                         async_tx_empty,
	// external interrupt pins, asynchronous
	input  wire logic [EXT_PINS-1:0]          ext_pins,
	// request to the cpu
	output logic                              cpu_irq
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [7:0]                  ctrl_q;
	logic [7:0]                  req0_q;
	logic [7:0]                  req1_q;
	logic [7:0]                  req2_q;
	logic [7:0]                  en0_q;
	logic [7:0]                  en1_q;
	logic [7:0]                  en2_q;
	logic [7:0]                  psel_q;
	logic [EXT_PINS-1:0]         pin_meta_q;
	logic [EXT_PINS-1:0]         pin_sync_q;
	logic                        ext_prev_q;
	logic                        awready_q;
	logic                        wready_q;
	logic                        aw_have_q;
	logic                        w_have_q;
	logic [pirq_pkg::ADDR_W-1:0] wr_addr_q;
	logic [7:0]                  wr_data_q;
	logic                        wr_strb_q;
	logic                        bvalid_q;
	logic [1:0]                  bresp_q;
	logic                        arready_q;
	logic                        rvalid_q;
	logic [31:0]                 rdata_q;
	logic [1:0]                  rresp_q;
	logic                        cpu_irq_q;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic hit(input logic [pirq_pkg::ADDR_W-1:0] a,
			input logic [15:0] idx);
		hit = (a == pirq_pkg::byte_addr(idx));
	endfunction

	// software write lands first, hardware set is ORed last so it wins
	function automatic logic [7:0] sticky_next(input logic [7:0] q,
			input logic [7:0] set, input logic wen,
			input logic [7:0] wdata, input logic [7:0] msk);
		sticky_next = ((wen ? wdata : q) | set) & msk;
	endfunction

	// ---------------------------------------------------------------
	// write channel
	// ---------------------------------------------------------------
	wire aw_take  = s_axi_awvalid && awready_q;
	wire w_take   = s_axi_wvalid && wready_q;
	wire wr_fire  = aw_have_q && w_have_q && !bvalid_q;
	wire b_done   = bvalid_q && s_axi_bready;
	wire wr_live  = wr_fire && wr_strb_q;

	wire wr_ctrl  = hit(wr_addr_q, pirq_pkg::IDX_CTRL);
	wire wr_req0  = hit(wr_addr_q, pirq_pkg::IDX_REQ0);
	wire wr_req1  = hit(wr_addr_q, pirq_pkg::IDX_REQ1);
	wire wr_req2  = hit(wr_addr_q, pirq_pkg::IDX_REQ2);
	wire wr_en0   = hit(wr_addr_q, pirq_pkg::IDX_EN0);
	wire wr_en1   = hit(wr_addr_q, pirq_pkg::IDX_EN1);
	wire wr_en2   = hit(wr_addr_q, pirq_pkg::IDX_EN2);
	wire wr_psel  = hit(wr_addr_q, pirq_pkg::IDX_PSEL);
	wire wr_known = wr_ctrl || wr_req0 || wr_req1 || wr_req2 ||
		wr_en0 || wr_en1 || wr_en2 || wr_psel;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			wr_addr_q <= '0;
			wr_data_q <= pirq_pkg::RST_BYTE;
			wr_strb_q <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= pirq_pkg::RESP_OKAY;
		end else begin
			if (aw_take) begin
				awready_q <= 1'b0;
				aw_have_q <= 1'b1;
				wr_addr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				wready_q  <= 1'b0;
				w_have_q  <= 1'b1;
				wr_data_q <= s_axi_wdata[7:0];
				wr_strb_q <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_known ? pirq_pkg::RESP_OKAY
					: pirq_pkg::RESP_SLVERR;
			end
			if (b_done) begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// external pin edge
	// ---------------------------------------------------------------
	// changing the pin select can look like one edge; clear the flag
	// after reselecting
	wire ext_level    = pin_sync_q[psel_q[$clog2(EXT_PINS+1)-1:0]
		% EXT_PINS];
	wire edge_rising  = (ctrl_q & pirq_pkg::MSK_EDGE) != 8'h00;
	wire ext_edge_evt = edge_rising ? (ext_level && !ext_prev_q)
		: (!ext_level && ext_prev_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
			ext_prev_q <= 1'b0;
		end else begin
			pin_meta_q <= ext_pins;
			pin_sync_q <= pin_meta_q;
			ext_prev_q <= ext_level;
		end
	end

	// ---------------------------------------------------------------
	// flag set vectors
	// ---------------------------------------------------------------
	wire pin_change_summary_flag = |per_pin_change_flags; // R6

	wire [7:0] set0 =
		(timer_a_overflow ? pirq_pkg::MSK_TIMER_A : 8'h00) | // R5 R8
		(ext_edge_evt     ? pirq_pkg::MSK_EXT     : 8'h00);  // R7

	wire [7:0] set1 =
		(capcmp_a_event        ? pirq_pkg::MSK_CAPCMP_A : 8'h00) | // R10
		(timer_c_event         ? pirq_pkg::MSK_TIMER_C  : 8'h00) | // R11
		(timer_b_event         ? pirq_pkg::MSK_TIMER_B  : 8'h00) |
		(sync_serial_event     ? pirq_pkg::MSK_SSER     : 8'h00) |
		(adc_done_event        ? pirq_pkg::MSK_ADC      : 8'h00) |
		(sync_serial_collision ? pirq_pkg::MSK_COLL     : 8'h00);  // R14

	wire [7:0] set2 =
		(capcmp_b_event        ? pirq_pkg::MSK_CAPCMP_B : 8'h00) | // R15
		(nonvol_done_event     ? pirq_pkg::MSK_NONVOL   : 8'h00) | // R16
		(timer_b_gate_inactive ? pirq_pkg::MSK_GATE_B   : 8'h00);  // R17

	// live views combine stored sticky bits with read-only levels
	wire [7:0] req0_view = req0_q |
		(pin_change_summary_flag ? pirq_pkg::MSK_PINCHG : 8'h00);
	wire [7:0] req1_view = req1_q |
		(async_rx_pending ? pirq_pkg::MSK_RX : 8'h00) | // R12
		(async_tx_empty   ? pirq_pkg::MSK_TX : 8'h00);  // R13

	// ---------------------------------------------------------------
	// register file
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= pirq_pkg::RST_BYTE;
			req0_q <= pirq_pkg::RST_BYTE;
			req1_q <= pirq_pkg::RST_BYTE;
			req2_q <= pirq_pkg::RST_BYTE;
			en0_q  <= pirq_pkg::RST_BYTE;
			en1_q  <= pirq_pkg::RST_BYTE;
			en2_q  <= pirq_pkg::RST_BYTE; // R3
			psel_q <= pirq_pkg::RST_BYTE;
		end else begin
			req0_q <= sticky_next(req0_q, set0, wr_live && wr_req0,
				wr_data_q, pirq_pkg::MSK_REQ0_RW); // R5 R7 R8
			req1_q <= sticky_next(req1_q, set1, wr_live && wr_req1,
				wr_data_q, pirq_pkg::MSK_REQ1_RW); // R10 R11 R14
			req2_q <= sticky_next(req2_q, set2, wr_live && wr_req2,
				wr_data_q, pirq_pkg::MSK_GRP2); // R15 R16 R17
			if (wr_live && wr_ctrl) begin
				ctrl_q <= wr_data_q & pirq_pkg::MSK_CTRL;
			end
			if (wr_live && wr_en0) begin
				en0_q <= wr_data_q & pirq_pkg::MSK_EN0;
			end
			if (wr_live && wr_en1) begin
				en1_q <= wr_data_q;
			end
			if (wr_live && wr_en2) begin
				en2_q <= wr_data_q & pirq_pkg::MSK_GRP2; // R1 R2 R3
			end
			if (wr_live && wr_psel) begin
				psel_q <= wr_data_q;
			end
		end
	end

	// ---------------------------------------------------------------
	// read channel
	// ---------------------------------------------------------------
	wire ar_take = s_axi_arvalid && arready_q;
	wire r_done  = rvalid_q && s_axi_rready;

	wire rd_ctrl = hit(s_axi_araddr, pirq_pkg::IDX_CTRL);
	wire rd_req0 = hit(s_axi_araddr, pirq_pkg::IDX_REQ0);
	wire rd_req1 = hit(s_axi_araddr, pirq_pkg::IDX_REQ1);
	wire rd_req2 = hit(s_axi_araddr, pirq_pkg::IDX_REQ2);
	wire rd_en0  = hit(s_axi_araddr, pirq_pkg::IDX_EN0);
	wire rd_en1  = hit(s_axi_araddr, pirq_pkg::IDX_EN1);
	wire rd_en2  = hit(s_axi_araddr, pirq_pkg::IDX_EN2);
	wire rd_psel = hit(s_axi_araddr, pirq_pkg::IDX_PSEL);
	wire rd_known = rd_ctrl || rd_req0 || rd_req1 || rd_req2 ||
		rd_en0 || rd_en1 || rd_en2 || rd_psel;

	wire [7:0] rd_byte =
		rd_ctrl ? ctrl_q :
		rd_req0 ? req0_view :
		rd_req1 ? req1_view :
		rd_req2 ? req2_q :
		rd_en0  ? en0_q :
		rd_en1  ? en1_q :
		rd_en2  ? en2_q :
		rd_psel ? psel_q : 8'h00;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= pirq_pkg::RDATA_RST;
			rresp_q   <= pirq_pkg::RESP_OKAY;
		end else begin
			if (ar_take) begin
				arready_q <= 1'b0;
				rvalid_q  <= 1'b1;
				rdata_q   <= {24'h000000, rd_byte};
				rresp_q   <= rd_known ? pirq_pkg::RESP_OKAY
					: pirq_pkg::RESP_SLVERR;
			end
			if (r_done) begin
				rvalid_q  <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// cpu request
	// ---------------------------------------------------------------
	wire gie_q     = (ctrl_q & pirq_pkg::MSK_GIE) != 8'h00;
	wire peripheral_irq_gate_q    = (ctrl_q & pirq_pkg::MSK_PERIPHERAL_IRQ_GATE) != 8'h00;
	wire grp0_hit  = (req0_view & en0_q) != 8'h00; // R18 R19
	wire grp12_hit = ((req1_view & en1_q) != 8'h00) ||
		((req2_q & en2_q) != 8'h00); // R1 R2 R3
	wire irq_d     = gie_q && (grp0_hit || (peripheral_irq_gate_q && grp12_hit)); // R4 R20

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpu_irq_q <= 1'b0;
		end else begin
			cpu_irq_q <= irq_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign cpu_irq       = cpu_irq_q;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	enable_store_a: assert property ( // R1
		(wr_live && wr_en2) |=>
			en2_q == ($past(wr_data_q) & pirq_pkg::MSK_GRP2))
		else $error("enable bank 2 did not store write");

	peri_gate_a: assert property ( // R4
		cpu_irq_q |-> $past(gie_q) && ($past(grp0_hit) || $past(peripheral_irq_gate_q)))
		else $error("request raised without its gates");

	timer_set_a: assert property ( // R5
		timer_a_overflow |=> req0_q[5])
		else $error("timer a overflow flag not set");

	pin_summary_a: assert property ( // R6
		(ar_take && rd_req0) |=> s_axi_rdata[4] ==
			$past(pin_change_summary_flag))
		else $error("pin change summary read wrong");

	ext_edge_a: assert property ( // R7
		(edge_rising && $rose(ext_level)) |=> req0_q[0])
		else $error("external edge did not set flag");

	sticky_hold_a: assert property ( // R10
		(req1_q[7] && !(wr_live && wr_req1)) |=> req1_q[7])
		else $error("capture flag dropped without write");

	collision_set_a: assert property ( // R14
		sync_serial_collision |=> req1_q[2])
		else $error("collision flag not set");

	rx_level_a: assert property ( // R12
		(ar_take && rd_req1) |=> s_axi_rdata[4] == $past(async_rx_pending))
		else $error("rx pending read wrong");

	ext_vector_a: assert property ( // R19
		(gie_q && en0_q[0] && req0_q[0]) |=> cpu_irq_q)
		else $error("external request not raised");

	gate_done_a: assert property ( // R17
		timer_b_gate_inactive |=> req2_q[5])
		else $error("gate flag not set");

endmodule

// ---- core/pirq_pkg.sv ----
package pirq_pkg;

	// ---------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam int unsigned ADDR_W   = 16;
	localparam logic [15:0] IDX_CTRL = 16'h000b;
	localparam logic [15:0] IDX_REQ0 = 16'h070c;
	localparam logic [15:0] IDX_REQ1 = 16'h070d;
	localparam logic [15:0] IDX_REQ2 = 16'h070e;
	localparam logic [15:0] IDX_EN0  = 16'h0716;
	localparam logic [15:0] IDX_EN1  = 16'h0717;
	localparam logic [15:0] IDX_EN2  = 16'h0718;
	localparam logic [15:0] IDX_PSEL = 16'h0720;

	// ---------------------------------------------------------------
	// field masks
	// ---------------------------------------------------------------
	localparam logic [7:0] MSK_GIE      = 8'h80;
	localparam logic [7:0] MSK_PERIPHERAL_IRQ_GATE     = 8'h40;
	localparam logic [7:0] MSK_EDGE     = 8'h01;
	localparam logic [7:0] MSK_CTRL     = 8'hc1;
	localparam logic [7:0] MSK_TIMER_A  = 8'h20;
	localparam logic [7:0] MSK_PINCHG   = 8'h10;
	localparam logic [7:0] MSK_EXT      = 8'h01;
	localparam logic [7:0] MSK_REQ0_RW  = 8'h21;
	localparam logic [7:0] MSK_CAPCMP_A = 8'h80;
	localparam logic [7:0] MSK_TIMER_C  = 8'h40;
	localparam logic [7:0] MSK_TIMER_B  = 8'h20;
	localparam logic [7:0] MSK_RX       = 8'h10;
	localparam logic [7:0] MSK_TX       = 8'h08;
	localparam logic [7:0] MSK_COLL     = 8'h04;
	localparam logic [7:0] MSK_SSER     = 8'h02;
	localparam logic [7:0] MSK_ADC      = 8'h01;
	localparam logic [7:0] MSK_REQ1_RW  = 8'he7;
	localparam logic [7:0] MSK_CAPCMP_B = 8'h80;
	localparam logic [7:0] MSK_NONVOL   = 8'h40;
	localparam logic [7:0] MSK_GATE_B   = 8'h20;
	localparam logic [7:0] MSK_GRP2     = 8'he0;
	localparam logic [7:0] MSK_EN0      = 8'h31;
	localparam logic [7:0] RST_BYTE     = 8'h00;

	// ---------------------------------------------------------------
	// bus constants
	// ---------------------------------------------------------------
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

	function automatic logic [15:0] byte_addr(input logic [15:0] idx);
		byte_addr = {idx[13:0], 2'h0};
	endfunction

endpackage

// ---- sim/pirq_bank_tb_top.sv ----
`timescale 1ns/100ps
module pirq_bank_tb_top;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic        aclk, aresetn, ev_fire, cpu_irq;
	logic [15:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, ext_pins, ev_sel;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, rx_lvl, tx_lvl;
	logic [11:0] chg;
	logic        tma, cca, tmc, tmb, sse, ssc, adc, ccb, nvd, gti;
	int          n_errors, n_tests;

	localparam logic [15:0] FIDX [10] = '{pirq_pkg::IDX_REQ0,
		pirq_pkg::IDX_REQ1, pirq_pkg::IDX_REQ1, pirq_pkg::IDX_REQ1,
		pirq_pkg::IDX_REQ1, pirq_pkg::IDX_REQ1, pirq_pkg::IDX_REQ1,
		pirq_pkg::IDX_REQ2, pirq_pkg::IDX_REQ2, pirq_pkg::IDX_REQ2};
	localparam logic [7:0] FMSK [10] = '{8'h20, 8'h80, 8'h40, 8'h20,
		8'h02, 8'h04, 8'h01, 8'h80, 8'h40, 8'h20};

	pirq_bank #(.EXT_PINS(4), .CHG_PINS(12)) dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.timer_a_overflow(tma), .capcmp_a_event(cca),
		.timer_c_event(tmc), .timer_b_event(tmb),
		.sync_serial_event(sse), .sync_serial_collision(ssc),
		.adc_done_event(adc), .capcmp_b_event(ccb),
		.nonvol_done_event(nvd), .timer_b_gate_inactive(gti),
		.per_pin_change_flags(chg), .async_rx_pending(rx_lvl),
		.async_tx_empty(tx_lvl), .ext_pins(ext_pins), .cpu_irq(cpu_irq)
	);

	pirq_sources src (
		.aclk(aclk), .aresetn(aresetn), .fire(ev_fire), .sel(ev_sel),
		.timer_a_overflow(tma), .capcmp_a_event(cca),
		.timer_c_event(tmc), .timer_b_event(tmb),
		.sync_serial_event(sse), .sync_serial_collision(ssc),
		.adc_done_event(adc), .capcmp_b_event(ccb),
		.nonvol_done_event(nvd), .timer_b_gate_inactive(gti)
	);

	// ---------------------------------------------------------------
	// bus and check tasks
	// ---------------------------------------------------------------
	function automatic logic [15:0] ba(input logic [15:0] i);
		ba = {i[13:0], 2'h0};
	endfunction

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask

	// handshakes are judged on what each rising edge samples; bready
	// and rready stay high once raised, so no call lowers and raises
	// them in one step
	task automatic axw(input logic [15:0] i, input logic [7:0] d,
		output logic [1:0] r);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok  = 1'b0;
		s_axi_awaddr  <= ba(i);
		s_axi_wdata   <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(aw_ok && w_ok));
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
	endtask

	task automatic axr(input logic [15:0] i, output logic [31:0] d,
		output logic [1:0] r);
		s_axi_araddr  <= ba(i);
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask

	task automatic wc(input logic [15:0] i, input logic [7:0] d);
		logic [1:0] r;
		axw(i, d, r);
		chk("bresp", 32'h0, {30'h0, r});
	endtask

	task automatic rc(input logic [15:0] i, input logic [7:0] e,
		input string nm);
		logic [31:0] d;
		logic [1:0]  r;
		axr(i, d, r);
		chk(nm, {24'h0, e}, d);
		chk("rresp", 32'h0, {30'h0, r});
	endtask

	task automatic fire_ev(input int k);
		ev_sel  <= k[3:0];
		ev_fire <= 1'b1;
		@(posedge aclk);
		ev_fire <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask

	task automatic ic(input logic e);
		repeat (3) @(posedge aclk);
		chk("cpu_irq", {31'h0, e}, {31'h0, cpu_irq});
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		rc(pirq_pkg::IDX_EN2, 8'h00, "en2 reset");
		rc(pirq_pkg::IDX_REQ1, 8'h00, "req1 reset");
		wc(pirq_pkg::IDX_EN2, 8'hff);
		rc(pirq_pkg::IDX_EN2, 8'he0, "en2 rw");
		wc(pirq_pkg::IDX_EN2, 8'h00);
		s_axi_wstrb <= 4'h0;
		wc(pirq_pkg::IDX_EN2, 8'hff);
		s_axi_wstrb <= 4'h1;
		rc(pirq_pkg::IDX_EN2, 8'h00, "en2 no strobe");
		axr(16'h0200, d, r);
		chk("unmapped rresp", 32'h2, {30'h0, r});
		chk("unmapped rdata", 32'h0, d);
		axw(16'h0200, 8'hff, r);
		chk("unmapped bresp", 32'h2, {30'h0, r});
	endtask

	task automatic t_flags();
		for (int k = 0; k < 10; k++) begin
			fire_ev(k);
			rc(FIDX[k], FMSK[k], $sformatf("flag %0d", k));
			wc(FIDX[k], 8'h00);
			rc(FIDX[k], 8'h00, $sformatf("flag clr %0d", k));
		end
	endtask

	task automatic t_live();
		chg <= 12'h800;
		repeat (2) @(posedge aclk);
		rc(pirq_pkg::IDX_REQ0, 8'h10, "pin change or");
		wc(pirq_pkg::IDX_REQ0, 8'h00);
		rc(pirq_pkg::IDX_REQ0, 8'h10, "pin change held");
		chg <= 12'h000;
		repeat (2) @(posedge aclk);
		rc(pirq_pkg::IDX_REQ0, 8'h00, "pin change gone");
		rx_lvl <= 1'b1;
		wc(pirq_pkg::IDX_REQ1, 8'hff);
		rc(pirq_pkg::IDX_REQ1, 8'hf7, "req1 read only");
		wc(pirq_pkg::IDX_REQ1, 8'h00);
		rc(pirq_pkg::IDX_REQ1, 8'h10, "rx pending");
		rx_lvl <= 1'b0;
		tx_lvl <= 1'b1;
		repeat (2) @(posedge aclk);
		rc(pirq_pkg::IDX_REQ1, 8'h08, "tx empty");
		tx_lvl <= 1'b0;
	endtask

	task automatic t_ext();
		ext_pins <= 4'h1;
		repeat (6) @(posedge aclk);
		rc(pirq_pkg::IDX_REQ0, 8'h00, "ext rising");
		ext_pins <= 4'h0;
		repeat (6) @(posedge aclk);
		rc(pirq_pkg::IDX_REQ0, 8'h01, "ext falling");
		// pin low and previous level low: switching to rising is quiet
		wc(pirq_pkg::IDX_CTRL, 8'h01);
		wc(pirq_pkg::IDX_REQ0, 8'h00);
		ext_pins <= 4'h1;
		repeat (6) @(posedge aclk);
		rc(pirq_pkg::IDX_REQ0, 8'h01, "ext rise set");
		wc(pirq_pkg::IDX_PSEL, 8'h01);
		wc(pirq_pkg::IDX_REQ0, 8'h00);
		ext_pins <= 4'h3;
		repeat (6) @(posedge aclk);
		rc(pirq_pkg::IDX_REQ0, 8'h01, "ext pin select");
		wc(pirq_pkg::IDX_CTRL, 8'h00);
	endtask

	task automatic t_irq();
		wc(pirq_pkg::IDX_EN0, 8'h01);
		wc(pirq_pkg::IDX_CTRL, 8'h80);
		ic(1'b1);
		wc(pirq_pkg::IDX_CTRL, 8'h00);
		ic(1'b0);
		wc(pirq_pkg::IDX_REQ0, 8'h00);
		fire_ev(0);
		wc(pirq_pkg::IDX_EN0, 8'h20);
		wc(pirq_pkg::IDX_CTRL, 8'h80);
		ic(1'b1);
		wc(pirq_pkg::IDX_EN0, 8'h00);
		ic(1'b0);
		fire_ev(6);
		wc(pirq_pkg::IDX_EN1, 8'h01);
		ic(1'b0);
		wc(pirq_pkg::IDX_CTRL, 8'hc0);
		ic(1'b1);
		wc(pirq_pkg::IDX_EN1, 8'h00);
		for (int k = 0; k < 3; k++) begin
			wc(pirq_pkg::IDX_CTRL, 8'h80);
			wc(pirq_pkg::IDX_REQ2, 8'h00);
			fire_ev(7 + k);
			wc(pirq_pkg::IDX_EN2, 8'h80 >> k);
			ic(1'b0);
			wc(pirq_pkg::IDX_CTRL, 8'hc0);
			ic(1'b1);
			wc(pirq_pkg::IDX_EN2, 8'h00);
			ic(1'b0);
		end
	endtask

	task automatic results();
		if (n_errors == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// clock, reset, sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	initial begin
		n_errors = 0;
		n_tests = 0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, ev_fire} = 3'h0;
		s_axi_awaddr = 16'h0000;
		s_axi_araddr = 16'h0000;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'h1;
		ext_pins = 4'h0;
		ev_sel = 4'h0;
		chg = 12'h000;
		rx_lvl = 1'b0;
		tx_lvl = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_flags();
		t_live();
		t_ext();
		t_irq();
		results();
	end

	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		results();
	end
endmodule

// ---- sim/pirq_sources.sv ----
`timescale 1ns/100ps
// ---------------------------------------------------------------
// peripheral event sources: one-cycle pulse on command
// ---------------------------------------------------------------
module pirq_sources (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// command from the bench
	input  wire logic       fire,
	input  wire logic [3:0] sel,
	// event pulses towards the bank
	output logic            timer_a_overflow,
	output logic            capcmp_a_event,
	output logic            timer_c_event,
	output logic            timer_b_event,
	output logic            sync_serial_event,
	output logic            sync_serial_collision,
	output logic            adc_done_event,
	output logic            capcmp_b_event,
	output logic            nonvol_done_event,
	output logic            timer_b_gate_inactive
);
	logic [9:0] pulse_q;

	// one cycle only, so a held level never re-sets a flag after a clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pulse_q <= 10'h000;
		end else begin
			pulse_q <= fire ? (10'h001 << sel) : 10'h000;
		end
	end
	assign timer_a_overflow      = pulse_q[0];
	assign capcmp_a_event        = pulse_q[1];
	assign timer_c_event         = pulse_q[2];
	assign timer_b_event         = pulse_q[3];
	assign sync_serial_event     = pulse_q[4];
	assign sync_serial_collision = pulse_q[5];
	assign adc_done_event        = pulse_q[6];
	assign capcmp_b_event        = pulse_q[7];
	assign nonvol_done_event     = pulse_q[8];
	assign timer_b_gate_inactive = pulse_q[9];
endmodule
